// ==== rtl/rtc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the clock control block.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ************************************************************
// Register map: the top sixteen locations of the address space.
// ************************************************************
`define RTC_TOP_BLOCK 15'h7FFF
`define RTC_ADDR_FLAGS 19'h7FFF0
`define RTC_ADDR_SPARE 19'h7FFF1
`define RTC_ADDR_ALM_SEC 19'h7FFF2
`define RTC_ADDR_ALM_DATE 19'h7FFF5
`define RTC_ADDR_ALM_EN 19'h7FFF6
`define RTC_ADDR_WDOG 19'h7FFF7
`define RTC_ADDR_CTRL 19'h7FFF8
`define RTC_SEL_FLAGS 4'h0
`define RTC_SEL_SPARE 4'h1
`define RTC_SEL_ALM_SEC 4'h2
`define RTC_SEL_ALM_DATE 4'h5
`define RTC_SEL_ALM_EN 4'h6
`define RTC_SEL_WDOG 4'h7

// ************************************************************
// Field positions.
// ************************************************************
`define RTC_CTRL_WRITE_HALT 7
`define RTC_CTRL_READ_HALT 6
`define RTC_SEC_OSC_STOP 7
`define RTC_DAY_FREQ_TEST 6
`define RTC_EN_ALARM_IRQ 7
`define RTC_EN_ALARM_BACKUP 5
`define RTC_WD_ROUTE 7
`define RTC_ALM_MASK_BIT 7
`define RTC_FLAG_WATCHDOG 7
`define RTC_FLAG_ALARM 6

// ************************************************************
// Timekeeping slots, reset values and BCD limits.
// ************************************************************
`define RTC_IX_CENT 3'h0
`define RTC_IX_SEC 3'h1
`define RTC_IX_MIN 3'h2
`define RTC_IX_HOUR 3'h3
`define RTC_IX_DAY 3'h4
`define RTC_IX_DATE 3'h5
`define RTC_IX_MONTH 3'h6
`define RTC_IX_YEAR 3'h7
`define RTC_KEEP_CTRL 8'hC0
`define RTC_KEEP_SEC 8'h80
`define RTC_KEEP_DAY 8'h40
`define RTC_BYTE_ZERO 8'h00
`define RTC_ONE_BCD 8'h01
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_HOUR 8'h23
`define RTC_MAX_DAY 8'h07
`define RTC_MAX_MONTH 8'h12
`define RTC_MAX_YEAR 8'h99
`define RTC_MAX_CENT 8'h39

// ************************************************************
// Timing.
// ************************************************************
`define RTC_CLK_HZ 50000000
`define RTC_FT_HZ 512
`define RTC_TICK_CYC (`RTC_CLK_HZ / (2 * `RTC_FT_HZ))
`define RTC_WD_PULSE_MIN_MS 40
`define RTC_WD_PULSE_CYC ((`RTC_WD_PULSE_MIN_MS * `RTC_CLK_HZ + 999) / 1000)
`define RTC_TICKS_PER_16TH 64
`define RTC_TICKS_PER_SEC 1024

`endif

// ==== rtl/rtc_ctrl.sv ====
// Clock control: timekeeping registers, alarm, frequency test and watchdog.
//
// Notes on behaviour
// - Write-halt bit freezes user timekeeping registers.
// - Host loads 24-hour BCD time while halted.
// - Clearing write-halt copies user values into counters.
// - 512 Hz on output under test conditions.
// - Power-up clears test, watchdog and alarm enables.
// - Mask bits choose the alarm repeat rate.
// - Undefined mask patterns alarm every second.
// - Match sets alarm flag; enable drives output.
// - Flags access releases alarm interrupt output.
// - Alarm flag clears at end of access.
// - On battery, output needs both alarm enables.
// - Power-up clears enables; match still sets flag.
// - Watchdog multiplier bits 6-2, resolution 1-0.
// - Timeout equals multiplier times resolution period.
// - Timeout sets flag and holds interrupt.
// - Route zero sends timeout to shared output.
// - Route one pulses reset output low.
// - Route one clears watchdog and test bit.
// - Watchdog access restarts the timeout count.
// - Zero in watchdog register disables it.
// - Enabled route-zero watchdog suppresses the test square wave.
// - Read-halt freezes user registers, counting continues.
// - Seconds bit 7 stops the oscillator.
`timescale 1ns/1ns
`include "rtc_cfg.svh"

module rtc_ctrl #(
    parameter int unsigned TICK_CYC = `RTC_TICK_CYC,
    parameter int unsigned PULSE_CYC = `RTC_WD_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic on_battery,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe,
    output logic interrupt_or_test_out_o,
    output logic interrupt_or_test_out_oe,
    output logic rst_out_o,
    output logic rst_out_oe
);
    localparam int unsigned PW = $clog2(PULSE_CYC + 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYC);
    localparam logic [PW-1:0] PULSE_ONE = PW'(1);

    // ************************************************************
    // Helper functions.
    // ************************************************************

    // Bits of a user slot that belong to control, not to the count.
    function automatic rtc_pkg::rtc_byte_t keep_mask(input logic [2:0] ix);
        case (ix)
            `RTC_IX_CENT: keep_mask = `RTC_KEEP_CTRL;
            `RTC_IX_SEC: keep_mask = `RTC_KEEP_SEC;
            `RTC_IX_DAY: keep_mask = `RTC_KEEP_DAY;
            default: keep_mask = `RTC_BYTE_ZERO;
        endcase
    endfunction

    // BCD increment with wrap; the top bit reports the wrap.
    function automatic logic [8:0] bcd_inc(input rtc_pkg::rtc_byte_t v,
                                           input rtc_pkg::rtc_byte_t maxv,
                                           input rtc_pkg::rtc_byte_t minv);
        if (v >= maxv) begin
            bcd_inc = {1'b1, minv};
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Last date of a month; a year divisible by four is a leap year.
    function automatic rtc_pkg::rtc_byte_t month_len(input rtc_pkg::rtc_byte_t mon,
                                                     input rtc_pkg::rtc_byte_t yr);
        logic [1:0] rem;
        rem = yr[1:0] + {yr[4], 1'b0};
        case (mon)
            8'h02: month_len = (rem == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // Alarm decision from the mask pattern and the field matches.
    function automatic logic alarm_hit(input logic [3:0] m, input logic s, input logic mi,
                                       input logic h, input logic d);
        case (m)
            4'hF: alarm_hit = 1'b1;
            4'hE: alarm_hit = s;
            4'hC: alarm_hit = s && mi;
            4'h8: alarm_hit = s && mi && h;
            4'h0: alarm_hit = s && mi && h && d;
            default: alarm_hit = 1'b1;
        endcase
    endfunction

    // Timeout length in sixteenths of a second.
    function automatic rtc_pkg::rtc_wd_count_t wd_period(input logic [4:0] mult,
                                                         input rtc_pkg::rtc_res_t res);
        rtc_pkg::rtc_wd_count_t base;
        base = {6'h00, mult};
        case (res)
            rtc_pkg::RTC_RES_16TH: wd_period = base;
            rtc_pkg::RTC_RES_QUARTER: wd_period = base << 2;
            rtc_pkg::RTC_RES_SECOND: wd_period = base << 4;
            rtc_pkg::RTC_RES_FOUR: wd_period = base << 6;
            default: wd_period = base;
        endcase
    endfunction

    // ************************************************************
    // State.
    // ************************************************************
    rtc_pkg::rtc_byte_t ext_q [0:7];
    rtc_pkg::rtc_byte_t int_q [0:7];
    rtc_pkg::rtc_byte_t step_d [0:7];
    rtc_pkg::rtc_byte_t alm_q [0:3];
    rtc_pkg::rtc_byte_t spare_q;
    rtc_pkg::rtc_byte_t alm_en_q;
    rtc_pkg::rtc_byte_t wd_q;
    rtc_pkg::rtc_byte_t rdata_d;
    rtc_pkg::rtc_wd_count_t wd_cnt_q;
    logic [PW-1:0] pulse_q;
    logic alarm_flag_q, watchdog_flag_q, alm_irq_q, wd_irq_q;
    logic flags_acc_q, w_prev_q, sec_evt_q, ft_sq_q;
    logic tick_1k, tick_1s, wd_tick;
    logic [5:0] wd_sub_q;

    // ************************************************************
    // Access decode.
    // ************************************************************
    logic hit, wr, rd, flags_acc, flags_end, wd_acc, w_fall, wd_en, wd_to;
    logic write_halt, read_halt, osc_run, freq_test_bit, alarm_irq_enable, backup_enable;
    logic watchdog_route, ft_on, alm_evt;
    logic [3:0] sel;
    logic [3:0] alarm_match_masks;
    logic [4:0] watchdog_multiplier;
    rtc_pkg::rtc_res_t watchdog_resolution;

    assign hit = (addr[18:4] == `RTC_TOP_BLOCK);
    assign sel = addr[3:0];
    assign wr = !ce_n && !we_n && hit;
    assign rd = !ce_n && !oe_n && we_n && hit;
    assign flags_acc = (wr || rd) && (sel == `RTC_SEL_FLAGS);
    assign flags_end = flags_acc_q && !flags_acc;
    assign wd_acc = (wr || rd) && (sel == `RTC_SEL_WDOG);
    assign write_halt = ext_q[`RTC_IX_CENT][`RTC_CTRL_WRITE_HALT];
    assign read_halt = ext_q[`RTC_IX_CENT][`RTC_CTRL_READ_HALT];
    assign osc_run = !ext_q[`RTC_IX_SEC][`RTC_SEC_OSC_STOP];
    assign freq_test_bit = ext_q[`RTC_IX_DAY][`RTC_DAY_FREQ_TEST];
    assign alarm_irq_enable = alm_en_q[`RTC_EN_ALARM_IRQ];
    assign backup_enable = alm_en_q[`RTC_EN_ALARM_BACKUP];
    assign watchdog_route = wd_q[`RTC_WD_ROUTE];
    assign watchdog_multiplier = wd_q[6:2];
    assign watchdog_resolution = rtc_pkg::rtc_res_t'(wd_q[1:0]);
    assign w_fall = w_prev_q && !write_halt;
    assign alarm_match_masks = {alm_q[3][`RTC_ALM_MASK_BIT], alm_q[2][`RTC_ALM_MASK_BIT],
                                alm_q[1][`RTC_ALM_MASK_BIT], alm_q[0][`RTC_ALM_MASK_BIT]};

    rtc_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .run(osc_run),
        .tick_1k(tick_1k),
        .tick_16(),
        .tick_1s(tick_1s)
    );

    // ************************************************************
    // Calendar.
    // ************************************************************

    // One second step of the internal counters, rippling carries upward.
    always_comb begin
        logic [8:0] r;
        logic c;
        r = 9'h000;
        c = 1'b0;
        for (int i = 0; i < 8; i++) begin
            step_d[i] = int_q[i];
        end
        r = bcd_inc(int_q[`RTC_IX_SEC], `RTC_MAX_SEC, `RTC_BYTE_ZERO);
        step_d[`RTC_IX_SEC] = r[7:0];
        c = r[8];
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_MIN], `RTC_MAX_SEC, `RTC_BYTE_ZERO);
            step_d[`RTC_IX_MIN] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_HOUR], `RTC_MAX_HOUR, `RTC_BYTE_ZERO);
            step_d[`RTC_IX_HOUR] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_DAY], `RTC_MAX_DAY, `RTC_ONE_BCD);
            step_d[`RTC_IX_DAY] = r[7:0];
            r = bcd_inc(int_q[`RTC_IX_DATE],
                        month_len(int_q[`RTC_IX_MONTH], int_q[`RTC_IX_YEAR]), `RTC_ONE_BCD);
            step_d[`RTC_IX_DATE] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_MONTH], `RTC_MAX_MONTH, `RTC_ONE_BCD);
            step_d[`RTC_IX_MONTH] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_YEAR], `RTC_MAX_YEAR, `RTC_BYTE_ZERO);
            step_d[`RTC_IX_YEAR] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bcd_inc(int_q[`RTC_IX_CENT], `RTC_MAX_CENT, `RTC_BYTE_ZERO);
            step_d[`RTC_IX_CENT] = r[7:0];
        end
    end

    // Internal counters keep running under either halt; release of write-halt reloads them.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= `RTC_BYTE_ZERO;
            end
            int_q[`RTC_IX_DAY] <= `RTC_ONE_BCD;
            int_q[`RTC_IX_DATE] <= `RTC_ONE_BCD;
            int_q[`RTC_IX_MONTH] <= `RTC_ONE_BCD;
        end else if (w_fall) begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= ext_q[i] & ~keep_mask(3'(i));
            end
        end else if (tick_1s) begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= step_d[i];
            end
        end
    end

    // User copy follows the counters unless halted; the copy never overwrites control bits.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                ext_q[i] <= `RTC_BYTE_ZERO;
            end
        end else begin
            if (!write_halt && !read_halt) begin
                for (int i = 0; i < 8; i++) begin
                    ext_q[i] <= (int_q[i] & ~keep_mask(3'(i))) | (ext_q[i] & keep_mask(3'(i)));
                end
            end
            if (wr && sel[3]) begin
                ext_q[sel[2:0]] <= data_i;
            end
            if (wd_to && watchdog_route) begin
                ext_q[`RTC_IX_DAY][`RTC_DAY_FREQ_TEST] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Alarm.
    // ************************************************************
    assign alm_evt = sec_evt_q && alarm_hit(alarm_match_masks,
        alm_q[0][6:0] == int_q[`RTC_IX_SEC][6:0],
        alm_q[1][6:0] == int_q[`RTC_IX_MIN][6:0],
        alm_q[2][5:0] == int_q[`RTC_IX_HOUR][5:0],
        alm_q[3][5:0] == int_q[`RTC_IX_DATE][5:0]);

    // Compare one cycle after the step, against the freshly counted value.
    always_ff @(posedge clk) begin
        if (rst) begin
            sec_evt_q <= 1'b0;
            w_prev_q <= 1'b0;
            flags_acc_q <= 1'b0;
        end else begin
            sec_evt_q <= tick_1s && !w_fall;
            w_prev_q <= write_halt;
            flags_acc_q <= flags_acc;
        end
    end

    // Alarm settings, spare byte and enables; enables clear on power-up.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                alm_q[i] <= `RTC_BYTE_ZERO;
            end
            spare_q <= `RTC_BYTE_ZERO;
            alm_en_q <= `RTC_BYTE_ZERO;
        end else if (wr) begin
            if (sel >= `RTC_SEL_ALM_SEC && sel <= `RTC_SEL_ALM_DATE) begin
                alm_q[2'(sel - `RTC_SEL_ALM_SEC)] <= data_i;
            end
            if (sel == `RTC_SEL_SPARE) begin
                spare_q <= data_i;
            end
            if (sel == `RTC_SEL_ALM_EN) begin
                alm_en_q <= data_i;
            end
        end
    end

    // A match sets the flag even during reset, so it can be read after power-up.
    always_ff @(posedge clk) begin
        if (alm_evt) begin
            alarm_flag_q <= 1'b1;
        end else if (rst || flags_end) begin
            alarm_flag_q <= 1'b0;
        end
    end

    // Interrupt from the alarm; a new match wins over a release in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            alm_irq_q <= 1'b0;
        end else if (alm_evt && alarm_irq_enable && (!on_battery || backup_enable)) begin
            alm_irq_q <= 1'b1;
        end else if (flags_acc) begin
            alm_irq_q <= 1'b0;
        end
    end

    // ************************************************************
    // Watchdog.
    // ************************************************************
    assign wd_en = (watchdog_multiplier != 5'h00);
    assign wd_tick = tick_1k && (wd_sub_q == 6'(`RTC_TICKS_PER_16TH - 1));
    assign wd_to = wd_en && wd_tick && !wd_acc &&
        (wd_cnt_q == wd_period(watchdog_multiplier, watchdog_resolution) - 11'h001);

    // Private sixteenth divider; restarting it with the count keeps a period from running short.
    always_ff @(posedge clk) begin
        if (rst || wd_acc || !wd_en || wd_to) begin
            wd_sub_q <= 6'h00;
        end else if (tick_1k) begin
            wd_sub_q <= wd_sub_q + 6'h01;
        end
    end

    // Any access to the watchdog register restarts the count.
    always_ff @(posedge clk) begin
        if (rst || wd_acc || !wd_en || wd_to) begin
            wd_cnt_q <= 11'h000;
        end else if (wd_tick) begin
            wd_cnt_q <= wd_cnt_q + 11'h001;
        end
    end

    // Register write, and self-clear when the timeout is routed to the reset pin.
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_q <= `RTC_BYTE_ZERO;
        end else if (wd_to && watchdog_route) begin
            wd_q <= `RTC_BYTE_ZERO;
        end else if (wr && sel == `RTC_SEL_WDOG) begin
            wd_q <= data_i;
        end
    end

    // Watchdog flag and interrupt; the timeout wins over a clearing access.
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_flag_q <= 1'b0;
            wd_irq_q <= 1'b0;
        end else begin
            if (wd_to) begin
                watchdog_flag_q <= 1'b1;
            end else if (flags_end) begin
                watchdog_flag_q <= 1'b0;
            end
            if (wd_to && !watchdog_route) begin
                wd_irq_q <= 1'b1;
            end else if (flags_acc || wd_acc) begin
                wd_irq_q <= 1'b0;
            end
        end
    end

    // Reset pulse of the least documented length; long, so it is a parameter.
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_q <= '0;
            rst_out_oe <= 1'b0;
        end else begin
            rst_out_oe <= (wd_to && watchdog_route) || (pulse_q > PULSE_ONE);
            if (wd_to && watchdog_route) begin
                pulse_q <= PULSE_LOAD;
            end else if (pulse_q != '0) begin
                pulse_q <= pulse_q - PULSE_ONE;
            end
        end
    end

    // ************************************************************
    // Shared interrupt and test pin, data bus.
    // ************************************************************
    assign ft_on = freq_test_bit && !alarm_irq_enable && osc_run &&
        (watchdog_route || wd_q == `RTC_BYTE_ZERO);

    // Square wave toggles on each 1024 Hz strobe; the pin is pulled low on the low half.
    always_ff @(posedge clk) begin
        if (rst) begin
            ft_sq_q <= 1'b1;
            interrupt_or_test_out_oe <= 1'b0;
            interrupt_or_test_out_o <= 1'b0;
            rst_out_o <= 1'b0;
        end else begin
            if (!ft_on) begin
                ft_sq_q <= 1'b1;
            end else if (tick_1k) begin
                ft_sq_q <= !ft_sq_q;
            end
            interrupt_or_test_out_oe <= alm_irq_q || wd_irq_q || (ft_on && !ft_sq_q);
            interrupt_or_test_out_o <= 1'b0;
            rst_out_o <= 1'b0;
        end
    end

    // Read data selection.
    always_comb begin
        rdata_d = `RTC_BYTE_ZERO;
        case (sel)
            `RTC_SEL_FLAGS: begin
                rdata_d[`RTC_FLAG_WATCHDOG] = watchdog_flag_q;
                rdata_d[`RTC_FLAG_ALARM] = alarm_flag_q;
            end
            `RTC_SEL_SPARE: rdata_d = spare_q;
            `RTC_SEL_ALM_EN: rdata_d = alm_en_q;
            `RTC_SEL_WDOG: rdata_d = wd_q;
            default: begin
                if (sel[3]) begin
                    rdata_d = ext_q[sel[2:0]];
                end else begin
                    rdata_d = alm_q[2'(sel - `RTC_SEL_ALM_SEC)];
                end
            end
        endcase
    end

    // Registered read path: one cycle from a sampled read to driven data.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_o <= `RTC_BYTE_ZERO;
            data_oe <= 1'b0;
        end else begin
            data_o <= rdata_d;
            data_oe <= rd;
        end
    end
endmodule

// ==== rtl/rtc_pkg.sv ====
// Types shared by the clock control block.
package rtc_pkg;
    typedef logic [7:0] rtc_byte_t;
    typedef logic [10:0] rtc_wd_count_t;
    typedef enum logic [1:0] {
        RTC_RES_16TH,
        RTC_RES_QUARTER,
        RTC_RES_SECOND,
        RTC_RES_FOUR
    } rtc_res_t;
endpackage

// ==== rtl/rtc_tick.sv ====
// Time base: derives 1024 Hz, 16 Hz and 1 Hz strobes from the system clock.
`timescale 1ns/1ns
`include "rtc_cfg.svh"

module rtc_tick #(
    parameter int unsigned TICK_CYC = `RTC_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic tick_1k,
    output logic tick_16,
    output logic tick_1s
);
    localparam int unsigned CW = $clog2(TICK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);
    localparam logic [9:0] SUB_16 = 10'(`RTC_TICKS_PER_16TH - 1);
    localparam logic [9:0] SUB_1S = 10'(`RTC_TICKS_PER_SEC - 1);

    logic [CW-1:0] cnt_q;
    logic [9:0] sub_q;
    logic step;

    assign step = run && (cnt_q == LAST);

    // Prescaler clears while the oscillator is stopped, so time does not drift forward.
    always_ff @(posedge clk) begin
        if (rst || !run || step) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // Sub-second counter and the registered strobes.
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_q <= 10'h000;
            tick_1k <= 1'b0;
            tick_16 <= 1'b0;
            tick_1s <= 1'b0;
        end else begin
            tick_1k <= step;
            tick_16 <= step && ((sub_q & SUB_16) == SUB_16);
            tick_1s <= step && (sub_q == SUB_1S);
            if (step) begin
                sub_q <= sub_q + 10'h001;
            end
        end
    end
endmodule

// ==== test/rtc_ctrl_bench.sv ====
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
module rtc_ctrl_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic on_battery = 1'b0;
    logic ce_n, oe_n, we_n, data_oe, interrupt_or_test_out_o, interrupt_or_test_out_oe, rst_out_o, rst_out_oe;
    logic [18:0] addr;
    logic [7:0] data_i, data_o, q;
    logic [3:0] m;
    int n_fail = 0;
    int checks_done = 0;
    int n;
    int mdl [16] = '{default: 0};
    always #10 clk = ~clk;
    rtc_ctrl #(.TICK_CYC(4), .PULSE_CYC(20)) i_dut (.clk(clk), .rst(rst),
        .on_battery(on_battery), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .interrupt_or_test_out_o(interrupt_or_test_out_o),
        .interrupt_or_test_out_oe(interrupt_or_test_out_oe), .rst_out_o(rst_out_o), .rst_out_oe(rst_out_oe));
    rtc_host_model i_host (.clk(clk), .data_o(data_o), .data_oe(data_oe), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .addr(addr), .data_i(data_i));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Writes go to the model too, so later reads know what to expect.
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        i_host.xfer(1'b1, {15'h7FFF, o}, d, q);
        mdl[o] = int'(d);
    endtask
    task automatic rdc(input logic [3:0] o);
        i_host.xfer(1'b0, {15'h7FFF, o}, 8'h00, q);
        cmp($sformatf("register %h", o), 8'(mdl[o]), q);
    endtask
    // Bounded wait for the interrupt pin or the reset pulse.
    task automatic await(input logic p, input int lim);
        for (n = 0; n < lim && (p ? rst_out_oe : interrupt_or_test_out_oe) !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == lim) begin
            n_fail++;
            $display("unexpected wait: expected event seen none");
            tally_and_finish;
        end
    endtask
    task automatic toggles;
        logic p;
        p = interrupt_or_test_out_oe;
        n = 0;
        repeat (64) begin
            @(negedge clk);
            n += int'(interrupt_or_test_out_oe !== p);
            p = interrupt_or_test_out_oe;
        end
    endtask
    initial begin
        void'($urandom(81958));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rdc(4'h7);
        rdc(4'h6);
        wr(4'h5, 8'($urandom));
        rdc(4'h5);
        // Every second, then an undefined mask that must act the same.
        for (int i = 0; i < 2; i++) begin
            m = i ? 4'h1 : 4'hF;
            for (int k = 0; k < 4; k++) begin
                wr(4'h2 + 4'(k), m[k] ? 8'h80 : 8'h00);
            end
            on_battery = i[0];
            wr(4'h6, i ? 8'hA0 : 8'h80);
            await(1'b0, 9000);
            mdl[0] = 8'h40;
            rdc(4'h0);
            mdl[0] = 0;
            rdc(4'h0);
            cmp("irq pin", 8'h00, 8'(interrupt_or_test_out_oe));
        end
        on_battery = 1'b0;
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h04);
        repeat (150) @(negedge clk);
        rdc(4'h7);
        await(1'b0, 400);
        cmp("watchdog period", 8'h01, 8'(n > 245 && n < 265));
        mdl[0] = 8'h80;
        rdc(4'h0);
        cmp("irq pin", 8'h00, 8'(interrupt_or_test_out_oe));
        wr(4'h7, 8'h84);
        await(1'b1, 400);
        repeat (25) @(negedge clk);
        mdl[7] = 0;
        rdc(4'h7);
        wr(4'h7, 8'h00);
        repeat (600) @(negedge clk);
        cmp("pins idle", 8'h00, 8'({interrupt_or_test_out_oe, rst_out_oe}));
        wr(4'h8, 8'h80);
        wr(4'hC, 8'h41);
        wr(4'h8, 8'h00);
        toggles();
        cmp("test toggles", 8'h01, 8'(n > 14 && n < 18));
        wr(4'h7, 8'h7C);
        repeat (8) @(negedge clk);
        toggles();
        cmp("suppressed toggles", 8'h00, 8'(n));
        tally_and_finish();
    end
endmodule
bind rtc_ctrl rtc_ctrl_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (.clk(clk), .rst(rst),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .data_oe(data_oe),
    .interrupt_or_test_out_o(interrupt_or_test_out_o), .interrupt_or_test_out_oe(interrupt_or_test_out_oe), .rst_out_o(rst_out_o),
    .rst_out_oe(rst_out_oe));

// ==== test/rtc_ctrl_checker.sv ====
// Port assertions for the clock control block.
`timescale 1ns/1ns
module rtc_ctrl_checker #(
    parameter int unsigned PULSE_CYC = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    input wire logic data_oe,
    input wire logic interrupt_or_test_out_o,
    input wire logic interrupt_or_test_out_oe,
    input wire logic rst_out_o,
    input wire logic rst_out_oe
);
    localparam int PH = PULSE_CYC - 1;
    // Bus cycles decoded the way the block samples them.
    wire logic top = addr[18:4] == 15'h7FFF;
    wire logic rd = !ce_n && top && we_n && !oe_n;
    wire logic fl = !ce_n && top && (!we_n || !oe_n) && addr[3:0] == 4'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (rd |=> data_oe)
        else $error("read not answered");
    AST_RD_RELEASE: assert property (!rd |=> !data_oe)
        else $error("data driven without read");
    AST_RD_STANDS: assert property (rd ##1 rd |-> data_oe)
        else $error("data dropped during read");
    AST_RESET_QUIET: assert property ($fell(rst) |-> !interrupt_or_test_out_oe && !rst_out_oe)
        else $error("outputs active after reset");
    AST_OD_LOW: assert property (interrupt_or_test_out_o == 1'b0 && rst_out_o == 1'b0)
        else $error("open drain value not low");
    AST_PULSE_LEN: assert property ($rose(rst_out_oe) |->
        (rst_out_oe throughout (1'b1 ##PH 1'b1)) ##1 !rst_out_oe)
        else $error("reset pulse length wrong");
    AST_PULSE_ONCE: assert property ($fell(rst_out_oe) |=> !rst_out_oe [*8])
        else $error("reset pulse rearmed");
    AST_FLAGS_CLEAR: assert property (fl [*4] |-> !interrupt_or_test_out_oe)
        else $error("interrupt held during flags access");
    cover property (fl [*4]);
    cover property ($rose(rst_out_oe));
    cover property ($rose(interrupt_or_test_out_oe));
endmodule

// ==== test/rtc_host_model.sv ====
// Host processor model issuing sram-style cycles to the clock control block.
`timescale 1ns/1ns
module rtc_host_model (
    input wire logic clk,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [18:0] addr,
    output logic [7:0] data_i
);
    // Idle bus from time zero.
    initial begin
        {ce_n, oe_n, we_n, addr, data_i} = '1;
    end
    // A cycle is held four clocks so a flags access surely clears the pin;
    // released lines carry the inverse so stale values never look valid.
    task automatic xfer(input logic w, input logic [18:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk);
        {ce_n, we_n, oe_n, addr, data_i} = {1'b0, !w, w, a, d};
        repeat (4) @(negedge clk);
        q = data_oe ? data_o : 8'hXX;
        {ce_n, we_n, oe_n, addr, data_i} = {3'h7, ~a, ~d};
    endtask
endmodule
